// ==== src/scrb_bank.sv ====
// serial-port register bank with shadowed per-channel registers
`timescale 1ns/1ps
`include "scrb_params.svh"

module scrb_bank #(
  parameter logic [63:0] LOCAL_MAP = 64'h1000_0000_0000_1100,
  parameter logic [7:0]  ID_CODE   = 8'h5a  // arbitrary value
) (
  input  wire logic               clk_i,        // core clock, 125 MHz
  input  wire logic               srst_i,       // sync reset, active high
  input  wire logic               sclk_i,       // serial shift clock
  input  wire logic               csb_i,        // chip select, active low
  input  wire logic               sdio_i,       // serial data in
  output logic                    sdio_o,       // serial data out
  output logic                    sdio_oe_o,    // high while driving sdio
  output scrb_pkg::scrb_bank_t    active_o,     // active register copies
  output logic                    commit_o      // pulse: copy performed
);
  // --------------------------------------------------------------------
  // reset into the serial domain
  // --------------------------------------------------------------------
  // sclk may stand still, so its registers reset asynchronously from a flop
  logic rst_lvl_r;
  always_ff @(posedge clk_i) begin
    rst_lvl_r <= srst_i;
  end

  function automatic scrb_pkg::scrb_bank_t rst_bank();
    scrb_pkg::scrb_bank_t b;
    for (int c = 0; c < `SCRB_NCH; c++) begin
      for (int i = 0; i < `SCRB_NSH; i++) begin
        b[c][i] = `SCRB_RST_SHD;
      end
      b[c][`SCRB_ADDR_SHUF - `SCRB_ADDR_SHD_LO] = `SCRB_RST_SHUF;
    end
    return b;
  endfunction

  // --------------------------------------------------------------------
  // frame shifter (sclk domain)
  // --------------------------------------------------------------------
  scrb_pkg::scrb_instr_t ins_r;
  logic [15:0]           sh_r;
  logic [3:0]            bit_cnt_r;
  logic [1:0]            bytes_r;
  logic                  in_data_r;
  logic                  done_r;
  logic [7:0]            cfg_r;
  logic [7:0]            idx_r;
  logic                  pend_r;
  logic                  tgl_r;
  scrb_pkg::scrb_bank_t  shd_r;

  wire        lsb_w      = cfg_r[`SCRB_CFG_LSB_HI];
  wire [15:0] sh_nxt     = lsb_w ? {sdio_i, sh_r[15:1]} : {sh_r[14:0], sdio_i};
  wire        instr_end  = !in_data_r && (bit_cnt_r == 4'hf);
  wire        byte_tick  = in_data_r && (bit_cnt_r == 4'h7);
  wire        byte_end   = byte_tick && !done_r;
  wire        last_byte  = byte_end && (ins_r.len != 2'h3) && (bytes_r == ins_r.len);
  wire [3:0]  bit_cnt_nxt = (instr_end || byte_tick) ? 4'h0 : bit_cnt_r + 4'h1;
  wire [`SCRB_AW-1:0] addr_step = lsb_w ? ins_r.addr + 13'h0001 : ins_r.addr - 13'h0001;
  wire [7:0]  wd         = lsb_w ? sh_nxt[15:8] : sh_nxt[7:0];

  // csb high ends the frame whatever the state of the shifter
  always_ff @(posedge sclk_i or posedge csb_i) begin
    if (csb_i) begin
      sh_r      <= 16'h0000;
      bit_cnt_r <= 4'h0;
      in_data_r <= 1'b0;
      done_r    <= 1'b0;
      bytes_r   <= 2'h0;
      ins_r     <= '0;
    end else begin
      sh_r      <= sh_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      in_data_r <= in_data_r | instr_end;
      done_r    <= done_r | last_byte;
      bytes_r   <= byte_end ? bytes_r + 2'h1 : bytes_r;
      ins_r     <= instr_end ? scrb_pkg::scrb_instr_t'(sh_nxt)
                 : byte_end  ? scrb_pkg::scrb_instr_t'({ins_r.rd, ins_r.len, addr_step})
                 : ins_r;
    end
  end

  // --------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------
  wire wr_fire  = byte_end && !ins_r.rd;
  wire wr_cfg   = wr_fire && (ins_r.addr == `SCRB_ADDR_CFG);
  wire wr_idx   = wr_fire && (ins_r.addr == `SCRB_ADDR_IDX);
  wire wr_xfer  = wr_fire && (ins_r.addr == `SCRB_ADDR_XFER) && wd[`SCRB_XFER_BIT];
  wire in_shd   = (ins_r.addr >= `SCRB_ADDR_SHD_LO) && (ins_r.addr <= `SCRB_ADDR_SHD_HI);
  wire wr_shd   = wr_fire && in_shd;
  wire soft_rst = wr_cfg && (wd[`SCRB_CFG_SRST_HI] || wd[`SCRB_CFG_SRST_LO]);
  wire is_local = LOCAL_MAP[ins_r.addr[5:0]];
  wire [5:0] sidx = 6'(ins_r.addr - `SCRB_ADDR_SHD_LO);
  wire lsb_wr   = wd[`SCRB_CFG_LSB_HI] | wd[`SCRB_CFG_LSB_LO];
  wire [`SCRB_NCH-1:0] wen = is_local ? idx_r[`SCRB_NCH-1:0] : {`SCRB_NCH{1'b1}};
  wire [7:0] glob_bits = (ins_r.addr == `SCRB_ADDR_PWR) ? `SCRB_PWR_GLOB : 8'h00;
  wire commit_go = wr_xfer || soft_rst;

  // soft reset bits are not stored, so they read back as zero
  always_ff @(posedge sclk_i or posedge rst_lvl_r) begin
    if (rst_lvl_r) begin
      cfg_r <= `SCRB_RST_CFG;
      idx_r <= `SCRB_RST_IDX;
    end else if (soft_rst) begin
      cfg_r <= `SCRB_RST_CFG;
      idx_r <= `SCRB_RST_IDX;
    end else begin
      if (wr_cfg)
        cfg_r <= {1'b0, lsb_wr, 1'b0, 2'b11, 1'b0, lsb_wr, 1'b0};
      if (wr_idx)
        idx_r <= wd & `SCRB_IDX_MASK;
    end
  end

  // shadow storage: one copy per channel, globals kept equal in all copies
  always_ff @(posedge sclk_i or posedge rst_lvl_r) begin
    if (rst_lvl_r) begin
      shd_r <= rst_bank();
    end else if (soft_rst) begin
      shd_r <= rst_bank();
    end else begin
      // global bits inside a local address still reach every copy
      for (int c = 0; c < `SCRB_NCH; c++) begin
        if (wr_shd)
          shd_r[c][sidx] <= wen[c] ? wd
                          : (shd_r[c][sidx] & ~glob_bits) | (wd & glob_bits);
      end
    end
  end

  // --------------------------------------------------------------------
  // commit handshake across domains
  // --------------------------------------------------------------------
  logic ack_s;
  logic ack_r;
  scrb_sync #(.W(1)) u_ack_sync (
    .clk_i (sclk_i),
    .rst_i (rst_lvl_r),
    .d_i   (ack_r),
    .q_o   (ack_s)
  );

  // a new command wins over the acknowledge of an older one
  always_ff @(posedge sclk_i or posedge rst_lvl_r) begin
    if (rst_lvl_r) begin
      pend_r <= 1'b0;
      tgl_r  <= 1'b0;
    end else if (commit_go) begin
      pend_r <= 1'b1;
      tgl_r  <= ~tgl_r;
    end else if (ack_s == tgl_r) begin
      pend_r <= 1'b0;
    end
  end

  logic tgl_s;
  logic copy_r;
  scrb_sync #(.W(1)) u_cmt_sync (
    .clk_i (clk_i),
    .rst_i (rst_lvl_r),
    .d_i   (tgl_r),
    .q_o   (tgl_s)
  );

  wire copy_go = (tgl_s != ack_r) && !srst_i;

  // shd_r is quiet here: the host needs a whole byte before touching it again
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_r    <= 1'b0;
      copy_r   <= 1'b0;
      active_o <= rst_bank();
    end else begin
      ack_r    <= tgl_s;
      copy_r   <= copy_go;
      if (copy_go)
        active_o <= shd_r;
    end
  end

  assign commit_o = copy_r;

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  wire [`SCRB_NCH-1:0] sel  = idx_r[`SCRB_NCH-1:0];
  wire                 one  = (sel != '0) && ((sel & (sel - 1'b1)) == '0);
  logic [1:0]          rd_ch;
  always_comb begin
    rd_ch = 2'h0;
    if (one) begin
      for (int c = `SCRB_NCH - 1; c >= 0; c--) begin
        if (sel[c])
          rd_ch = 2'(c);
      end
    end
  end

  wire [7:0] rd_byte =
      (ins_r.addr == `SCRB_ADDR_CFG)  ? cfg_r :
      (ins_r.addr == `SCRB_ADDR_ID)   ? ID_CODE :
      (ins_r.addr == `SCRB_ADDR_IDX)  ? idx_r :
      (ins_r.addr == `SCRB_ADDR_XFER) ? {7'h00, pend_r} :
      in_shd                          ? shd_r[rd_ch][sidx] :
                                        8'h00;
  wire [2:0] out_pos = lsb_w ? bit_cnt_r[2:0] : 3'h7 - bit_cnt_r[2:0];

  // output changes on the falling edge so the host samples it on the rise
  always_ff @(negedge sclk_i or posedge csb_i) begin
    if (csb_i) begin
      sdio_o    <= 1'b0;
      sdio_oe_o <= 1'b0;
    end else begin
      sdio_o    <= rd_byte[out_pos];
      sdio_oe_o <= in_data_r && ins_r.rd && !done_r;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence s_commit_seen;
    (tgl_s != ack_r) ##1 copy_r;
  endsequence

  a_commit_copy: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (copy_go && $stable(shd_r)) |=> (active_o == $past(shd_r)))
    else $error("active copy differs from shadow after commit");

  a_active_hold: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !copy_go |=> $stable(active_o))
    else $error("active registers changed without commit");

  a_commit_pulse: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (tgl_s != ack_r) |-> s_commit_seen)
    else $error("commit pulse missing after toggle");

  a_reset_load: assert property (
    @(posedge clk_i) srst_i |=> (active_o == rst_bank()))
    else $error("active registers not at defaults after reset");

  a_xfer_clear: assert property (
    @(posedge sclk_i) disable iff (rst_lvl_r)
    (pend_r && !commit_go && ack_s == tgl_r) |=> !pend_r)
    else $error("transfer bit did not clear after acknowledge");
  a_local_write: assert property (
    @(posedge sclk_i) disable iff (rst_lvl_r)
    (wr_shd && is_local && !soft_rst) |=> (shd_r[0][$past(sidx)] == ($past(idx_r[0]) ? $past(wd)
        : (($past(shd_r[0][sidx]) & ~$past(glob_bits)) | ($past(wd) & $past(glob_bits))))))
    else $error("channel A copy wrong after local write");
  a_global_write: assert property (
    @(posedge sclk_i) disable iff (rst_lvl_r)
    (wr_shd && !is_local && !soft_rst) |=> (shd_r[`SCRB_NCH-1][$past(sidx)] == $past(wd)))
    else $error("global write missed a channel copy");
  a_multi_read: assert property (
    @(posedge sclk_i) disable iff (rst_lvl_r)
    !one |-> (rd_ch == 2'h0))
    else $error("multi-channel read not from channel A");

  a_cfg_mirror: assert property (
    @(posedge sclk_i) disable iff (rst_lvl_r)
    (cfg_r[`SCRB_CFG_LSB_HI] == cfg_r[`SCRB_CFG_LSB_LO]) && (cfg_r[4:3] == 2'b11))
    else $error("port setup nibbles not mirrored");

  a_id_read: assert property (
    @(posedge sclk_i) disable iff (rst_lvl_r)
    (ins_r.addr == `SCRB_ADDR_ID) |-> (rd_byte == ID_CODE))
    else $error("identifier read differs from constant");

  a_instr_len: assert property (
    @(posedge sclk_i) disable iff (rst_lvl_r || csb_i)
    instr_end |=> (in_data_r && bit_cnt_r == 4'h0))
    else $error("data phase did not start after 16 bits");
endmodule

// ==== src/scrb_params.svh ====
// constants of the shadowed channel register bank
`ifndef SCRB_PARAMS_SVH
`define SCRB_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SCRB_AW          13
`define SCRB_ADDR_CFG    13'h0000
`define SCRB_ADDR_ID     13'h0001
`define SCRB_ADDR_IDX    13'h0005
`define SCRB_ADDR_XFER   13'h00ff
`define SCRB_ADDR_SHD_LO 13'h0008
`define SCRB_ADDR_SHD_HI 13'h003e
`define SCRB_ADDR_SHUF   13'h000c
`define SCRB_ADDR_PWR    13'h0008

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define SCRB_NSH         55
`define SCRB_NCH         4
`define SCRB_INSTR_BITS  16
`define SCRB_BYTE_BITS   8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SCRB_RST_CFG     8'h18
`define SCRB_RST_IDX     8'hcf
`define SCRB_RST_SHUF    8'h01
`define SCRB_RST_SHD     8'h00

// ----------------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------------
`define SCRB_CFG_LSB_HI  6
`define SCRB_CFG_LSB_LO  1
`define SCRB_CFG_SRST_HI 5
`define SCRB_CFG_SRST_LO 2
`define SCRB_XFER_BIT    0
`define SCRB_IDX_MASK    8'hcf
`define SCRB_PWR_GLOB    8'h20

`endif

// ==== src/scrb_pkg.sv ====
// types shared by the shadowed channel register bank
`include "scrb_params.svh"

package scrb_pkg;
  typedef logic [7:0] scrb_byte_t;
  typedef scrb_byte_t [`SCRB_NSH-1:0] scrb_chan_t;
  typedef scrb_chan_t [`SCRB_NCH-1:0] scrb_bank_t;

  // instruction word as it lands in the shifter
  typedef struct packed {
    logic                 rd;
    logic [1:0]           len;
    logic [`SCRB_AW-1:0]  addr;
  } scrb_instr_t;
endpackage

// ==== src/scrb_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps

module scrb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // destination clock
  input  wire logic         rst_i,  // async reset, active high
  input  wire logic [W-1:0] d_i,    // level from the other domain
  output logic      [W-1:0] q_o     // synchronised level
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule

// ==== tb/scrb_host.sv ====
// serial host model that drives one-byte frames on the configuration port
`timescale 1ns/1ps

module scrb_host (
  output logic      sclk_o,  // shift clock, still outside frames
  output logic      csb_o,   // chip select, active low
  output logic      bit_o,   // bit the host puts on sdio
  output logic      en_o,    // high while the host drives sdio
  input  wire logic sdio_i   // resolved sdio wire
);
  initial begin
    sclk_o = 1'b0;
    csb_o  = 1'b1;
    bit_o  = 1'b0;
    en_o   = 1'b0;
  end

  // ----------------------------------------------------------------------
  // frame: instruction then one byte, msb first unless lf is set, 12 ns shift period
  // ----------------------------------------------------------------------
  task automatic frame(input logic lf, input logic rd, input logic [12:0] a,
                       input logic [7:0] d, output logic [7:0] q);
    logic [23:0] w;
    int          j;
    w = {rd, 2'b00, a, d};
    q = 8'h00;
    // gap keeps csb high between frames
    #20 csb_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // lsb-first sends instruction and data each low bit first
      j     = !lf ? i : (i >= 8) ? 31 - i : 7 - i;
      en_o  = !(rd && i < 8);
      bit_o = w[j];
      #6 sclk_o = 1'b1;
      if (i < 8) q[j] = sdio_i;
      #6 sclk_o = 1'b0;
    end
    en_o  = 1'b0;
    csb_o = 1'b1;
  endtask
endmodule

// ==== tb/tb_shadowed_channel_register_bank.sv ====
// self-checking bench of the shadowed channel register bank
`timescale 1ns/1ps
`include "scrb_params.svh"

module tb_shadowed_channel_register_bank;
  localparam logic [7:0] ID = 8'h5a;  // arbitrary value

  logic                 clk_i = 1'b0;
  logic                 srst_i = 1'b1;
  wire                  sclk_w;
  wire                  csb_w;
  wire                  hbit_w;
  wire                  hen_w;
  logic                 sdio_o;
  logic                 sdio_oe_o;
  wire                  sdio_w;
  scrb_pkg::scrb_bank_t active_o;
  logic                 commit_o;
  int                   num_errors = 0;
  int                   n_compared = 0;
  int                   seed = 32'h18b6;
  scrb_pkg::scrb_byte_t q;
  scrb_pkg::scrb_byte_t v;
  scrb_pkg::scrb_byte_t x [4];
  logic [3:0]           sel;
  logic                 lf = 1'b0;

  always #4 clk_i = ~clk_i;
  // a released wire shows the inverse of the host's last bit
  assign sdio_w = sdio_oe_o ? sdio_o : (hen_w ? hbit_w : ~hbit_w);

  scrb_bank #(.ID_CODE(ID)) scrb_bank_inst (
    .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_w), .csb_i(csb_w), .sdio_i(sdio_w),
    .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .active_o(active_o), .commit_o(commit_o));

  scrb_host scrb_host_inst (
    .sclk_o(sclk_w), .csb_o(csb_w), .bit_o(hbit_w), .en_o(hen_w), .sdio_i(sdio_w));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input scrb_pkg::scrb_byte_t e,
                     input scrb_pkg::scrb_byte_t g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [12:0] a, input scrb_pkg::scrb_byte_t d);
    scrb_host_inst.frame(lf, 1'b0, a, d, q);
  endtask

  task automatic rd(input logic [12:0] a, input scrb_pkg::scrb_byte_t e, input string n);
    scrb_host_inst.frame(lf, 1'b1, a, 8'h00, q);
    chk(n, e, q);
  endtask

  // waits for the copy pulse, then checks address a in every channel
  task automatic wait_chk(input int a);
    int k;
    k = 0;
    while (commit_o !== 1'b1 && k < 40) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk("commit", 8'h01, {7'h00, commit_o});
    for (int c = 0; c < 4; c++) chk("active", x[c], active_o[c][a-8]);
  endtask

  function automatic scrb_pkg::scrb_byte_t rd_exp(input logic [3:0] s);
    for (int c = 0; c < 4; c++) if (s == (4'h1 << c)) return x[c];
    return x[0];
  endfunction

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    #1 srst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rd(`SCRB_ADDR_CFG, 8'h18, "setup");
    rd(`SCRB_ADDR_ID, ID, "ident");
    rd(`SCRB_ADDR_IDX, 8'hcf, "index");
    chk("shuffle dflt", 8'h01, active_o[2][4]);
    wr(`SCRB_ADDR_ID, ~ID);
    rd(`SCRB_ADDR_ID, ID, "ident ro");
    // global register written with only channel b selected
    wr(`SCRB_ADDR_IDX, 8'h02);
    v = 8'($random(seed)) & 8'h3f;
    wr(13'h000b, v);
    chk("held", 8'h00, active_o[3][3]);
    rd(13'h000b, v, "shadow");
    x = '{v, v, v, v};
    wr(`SCRB_ADDR_XFER, 8'h01);
    wait_chk(11);
    rd(`SCRB_ADDR_XFER, 8'h00, "xfer clr");
    x = '{8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      sel = (i == 0) ? 4'hf : 4'($random(seed));
      if (sel == 4'h0) sel = 4'h3;
      // unused bits of power modes stay zero
      v = 8'($random(seed)) & 8'h23;
      wr(`SCRB_ADDR_IDX, {4'h0, sel});
      wr(13'h0008, v);
      chk("held local", x[0], active_o[0][0]);
      // bit 5 of power modes is global and lands in every copy
      for (int c = 0; c < 4; c++) x[c] = sel[c] ? v : (x[c] & 8'hdf) | (v & 8'h20);
      wr(`SCRB_ADDR_XFER, 8'h01);
      wait_chk(8);
      rd(13'h0008, rd_exp(sel), "sel read");
    end
    for (int c = 0; c < 4; c++) begin
      wr(`SCRB_ADDR_IDX, 8'h01 << c);
      rd(13'h0008, x[c], "local");
      rd(13'h000c, 8'h01, "shuffle");
    end
    // mirrored setup byte switches to lsb-first in either order
    wr(`SCRB_ADDR_CFG, 8'h5a);
    lf = 1'b1;
    rd(`SCRB_ADDR_CFG, 8'h5a, "setup lsb");
    v = 8'($random(seed)) & 8'h3f;
    wr(13'h000b, v);
    rd(13'h000b, v, "lsb shadow");
    // soft reset reloads defaults and copies them out; 0x3c reads alike both ways
    wr(`SCRB_ADDR_CFG, 8'h3c);
    lf = 1'b0;
    x = '{8'h00, 8'h00, 8'h00, 8'h00};
    wait_chk(8);
    chk("sr global", 8'h00, active_o[1][3]);
    rd(`SCRB_ADDR_CFG, 8'h18, "setup sr");
    rd(`SCRB_ADDR_IDX, 8'hcf, "index sr");
    close_out();
  end

  initial begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule
